/* rtl/fpp_pkg.sv */
// constants for the four-pin port with serial pin selection
package fpp_pkg;
  // register indices; byte address is four times the index
  localparam int unsigned ADDR_W = 18;
  localparam logic [15:0] IDX_DATA  = 16'hffd7;
  localparam logic [15:0] IDX_DIR   = 16'hffe7;
  localparam logic [15:0] IDX_IMODE = 16'hfff0;
  localparam logic [15:0] IDX_SCTL  = 16'hfff1;
  localparam logic [15:0] IDX_SMODE = 16'hfff2;
  localparam logic [15:0] IDX_SPIN  = 16'hfff3;
  localparam logic [15:0] IDX_PWR   = 16'hfff4;

  // reset and read values
  localparam logic [7:0] DATA_RST  = 8'hf8;
  localparam logic [7:0] DIR_RST   = 8'hf8;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] UPPER_ONE = 8'hf8;
  localparam logic [7:0] DIR_READ  = 8'hff;

  // field positions
  localparam int unsigned GP_W          = 3;
  localparam int unsigned IMODE_IRQ_BIT = 0;
  localparam int unsigned SCTL_TE_BIT   = 5;
  localparam int unsigned SCTL_RE_BIT   = 4;
  localparam int unsigned SCTL_CKE1_BIT = 1;
  localparam int unsigned SCTL_CKE0_BIT = 0;
  localparam int unsigned SMODE_COM_BIT = 7;
  localparam int unsigned SPIN_SPC_BIT  = 0;
  localparam int unsigned PWR_LO_BIT    = 0;
  localparam int unsigned PWR_HI_BIT    = 1;

  // operating modes
  typedef enum logic [1:0] {
    FPP_ACTIVE    = 2'h0,
    FPP_SUBACTIVE = 2'h1,
    FPP_SLEEP     = 2'h2,
    FPP_STANDBY   = 2'h3
  } fpp_pwr_e;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/fpp_port.sv */
// four-pin general-purpose port with serial and interrupt pin selection
//
// Contract
// - three bidirectional pins at bits 2..0, one input-only pin at bit 3
// - data latch resets to f8: upper bits one, data bits zero
// - read with direction bit 1 returns latched data, not pin level
// - read with direction bit 0 returns the sampled pin level
// - direction 1 drives latched data out, direction 0 makes an input
// - direction and data act only while the pin is in port use
// - direction register resets to f8, so all three pins are inputs
// - direction register is write-only and always reads all ones
// - input pin is port input, or interrupt request when select is one
// - pin 2 is transmit output when pin-enable and transmit-enable are one
// - pin 1 is receive input when receive-enable is one
// - pin 0 clock input on enable high, clock output on enable low with cke0 or sync
// - pins float in reset and standby, hold in sleep, else work
//
// The AXI4-Lite slave port was decided locally.
module fpp_port (
  input  wire logic [17:0] S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [17:0] S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  input  wire logic        CORE_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [3:0]  PIN_I,
  output logic [2:0]       PIN_O,
  output logic [2:0]       PIN_OE_N_O,
  input  wire logic        SER_TXD_I,
  input  wire logic        SER_SCK_I,
  output logic             SER_RXD_O,
  output logic             SER_SCK_O,
  output logic             EXT_IRQ_N_O
);

  // software-visible state
  logic [2:0] data_latch;
  logic [2:0] dir;
  logic       irq_sel;
  logic       te;
  logic       re;
  logic       cke1;
  logic       cke0;
  logic       com;
  logic       spc;
  logic [1:0] pwr;

  // bus handshakes
  logic       aw_ready;
  logic       b_valid;
  logic [1:0] b_resp;
  logic       ar_ready;
  logic       r_valid;
  logic [1:0] r_resp;
  logic [7:0] r_data;

  // pin drivers
  logic [2:0] pin_o;
  logic [2:0] pin_oe_n;
  logic       rxd;
  logic       sck_in;
  logic       irq_n;

  // write decode
  wire [15:0] wr_idx   = S_AXI_AWADDR_I[17:2];
  wire        wr_fire  = aw_ready & S_AXI_AWVALID_I & S_AXI_WVALID_I;
  wire        wr_lane  = S_AXI_WSTRB_I[0];
  wire        wr_en    = wr_fire & wr_lane;
  wire [7:0]  wr_byte  = S_AXI_WDATA_I[7:0];
  wire        hit_data = (wr_idx == fpp_pkg::IDX_DATA);
  wire        hit_dir  = (wr_idx == fpp_pkg::IDX_DIR);
  wire        hit_imod = (wr_idx == fpp_pkg::IDX_IMODE);
  wire        hit_sctl = (wr_idx == fpp_pkg::IDX_SCTL);
  wire        hit_smod = (wr_idx == fpp_pkg::IDX_SMODE);
  wire        hit_spin = (wr_idx == fpp_pkg::IDX_SPIN);
  wire        hit_pwr  = (wr_idx == fpp_pkg::IDX_PWR);
  wire        wr_known = hit_data | hit_dir | hit_imod | hit_sctl |
                         hit_smod | hit_spin | hit_pwr;
  // a write is taken only with both channels present; slave may wait
  wire        next_aw_ready = ~aw_ready & ~b_valid &
                              S_AXI_AWVALID_I & S_AXI_WVALID_I;

  // pin function selection
  wire tx_sel   = spc & te;
  wire rx_sel   = re;
  wire sck_isel = cke1;
  wire sck_osel = ~cke1 & (cke0 | com);

  // drive enables, active high here, port use only when no function
  wire [2:0] drive;
  assign drive[2] = tx_sel ? 1'b1 : dir[2];
  assign drive[1] = rx_sel ? 1'b0 : dir[1];
  assign drive[0] = sck_isel ? 1'b0 :
                    sck_osel ? 1'b1 : dir[0];

  wire [2:0] func_o;
  assign func_o[2] = tx_sel ? SER_TXD_I : data_latch[2];
  assign func_o[1] = data_latch[1];
  assign func_o[0] = sck_osel ? SER_SCK_I : data_latch[0];

  // operating mode
  wire in_sleep   = (pwr == fpp_pkg::FPP_SLEEP);
  wire in_standby = (pwr == fpp_pkg::FPP_STANDBY);

  // sleep freezes the pins as they were; standby floats them
  wire [2:0] next_pin_oe_n = in_standby ? 3'b111 :
                             in_sleep   ? pin_oe_n : ~drive;
  wire [2:0] next_pin_o    = in_sleep ? pin_o : func_o;

  // port read value
  wire [2:0] gp_read = (dir & data_latch) |
                       (~dir & PIN_I[2:0]);
  wire       b3_read = irq_sel ? 1'b1 : PIN_I[3];
  wire [7:0] data_read = {fpp_pkg::UPPER_ONE[7:4], b3_read,
                          gp_read};

  // read decode
  wire [15:0] rd_idx  = S_AXI_ARADDR_I[17:2];
  wire        rd_fire = ar_ready & S_AXI_ARVALID_I;
  wire        next_ar_ready = ~ar_ready & ~r_valid & S_AXI_ARVALID_I;
  wire [7:0]  sctl_read = {2'h0, te, re, 2'h0, cke1, cke0};
  wire [7:0]  rd_val =
    (rd_idx == fpp_pkg::IDX_DATA)  ? data_read :
    (rd_idx == fpp_pkg::IDX_DIR)   ? fpp_pkg::DIR_READ :
    (rd_idx == fpp_pkg::IDX_IMODE) ? {7'h00, irq_sel} :
    (rd_idx == fpp_pkg::IDX_SCTL)  ? sctl_read :
    (rd_idx == fpp_pkg::IDX_SMODE) ? {com, 7'h00} :
    (rd_idx == fpp_pkg::IDX_SPIN)  ? {7'h00, spc} :
    (rd_idx == fpp_pkg::IDX_PWR)   ? {6'h00, pwr} : 8'h00;
  wire        rd_known =
    (rd_idx == fpp_pkg::IDX_DATA)  | (rd_idx == fpp_pkg::IDX_DIR)  |
    (rd_idx == fpp_pkg::IDX_IMODE) | (rd_idx == fpp_pkg::IDX_SCTL) |
    (rd_idx == fpp_pkg::IDX_SMODE) | (rd_idx == fpp_pkg::IDX_SPIN) |
    (rd_idx == fpp_pkg::IDX_PWR);

  // data and direction registers; only bits 2..0 are stored
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      data_latch <= fpp_pkg::DATA_RST[2:0];
      dir        <= fpp_pkg::DIR_RST[2:0];
    end else begin
      if (wr_en && hit_data) begin
        data_latch <= wr_byte[2:0];
      end
      if (wr_en && hit_dir) begin
        dir <= wr_byte[2:0];
      end
    end
  end

  // pin selection controls
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      irq_sel <= fpp_pkg::CTRL_RST[0];
      te      <= fpp_pkg::CTRL_RST[0];
      re      <= fpp_pkg::CTRL_RST[0];
      cke1    <= fpp_pkg::CTRL_RST[0];
      cke0    <= fpp_pkg::CTRL_RST[0];
      com     <= fpp_pkg::CTRL_RST[0];
      spc     <= fpp_pkg::CTRL_RST[0];
    end else begin
      if (wr_en && hit_imod) begin
        irq_sel <= wr_byte[fpp_pkg::IMODE_IRQ_BIT];
      end
      if (wr_en && hit_sctl) begin
        te   <= wr_byte[fpp_pkg::SCTL_TE_BIT];
        re   <= wr_byte[fpp_pkg::SCTL_RE_BIT];
        cke1 <= wr_byte[fpp_pkg::SCTL_CKE1_BIT];
        cke0 <= wr_byte[fpp_pkg::SCTL_CKE0_BIT];
      end
      if (wr_en && hit_smod) begin
        com <= wr_byte[fpp_pkg::SMODE_COM_BIT];
      end
      if (wr_en && hit_spin) begin
        spc <= wr_byte[fpp_pkg::SPIN_SPC_BIT];
      end
    end
  end

  // operating mode
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      pwr <= fpp_pkg::CTRL_RST[1:0];
    end else if (wr_en && hit_pwr) begin
      pwr <= wr_byte[fpp_pkg::PWR_HI_BIT:fpp_pkg::PWR_LO_BIT];
    end
  end

  // write channel
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      aw_ready <= 1'b0;
      b_valid  <= 1'b0;
      b_resp   <= fpp_pkg::RESP_OKAY;
    end else begin
      aw_ready <= next_aw_ready;
      if (wr_fire) begin
        b_valid <= 1'b1;
        b_resp  <= wr_known ? fpp_pkg::RESP_OKAY : fpp_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
        b_valid <= 1'b0;
      end
    end
  end

  // read channel; pin level is sampled at the address edge
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      ar_ready <= 1'b0;
      r_valid  <= 1'b0;
      r_resp   <= fpp_pkg::RESP_OKAY;
      r_data   <= 8'h00;
    end else begin
      ar_ready <= next_ar_ready;
      if (rd_fire) begin
        r_valid <= 1'b1;
        r_data  <= rd_val;
        r_resp  <= rd_known ? fpp_pkg::RESP_OKAY : fpp_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY_I) begin
        r_valid <= 1'b0;
      end
    end
  end

  // pin and function outputs; reset floats all pins
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      pin_o    <= 3'h0;
      pin_oe_n <= 3'h7;
      rxd      <= 1'b1;
      sck_in   <= 1'b1;
      irq_n    <= 1'b1;
    end else begin
      pin_o    <= next_pin_o;
      pin_oe_n <= next_pin_oe_n;
      rxd      <= rx_sel ? PIN_I[1] : 1'b1;
      sck_in   <= sck_isel ? PIN_I[0] : 1'b1;
      irq_n    <= irq_sel ? PIN_I[3] : 1'b1;
    end
  end

  // one cycle of latency on every function path, kept for flop outputs
  assign S_AXI_AWREADY_O = aw_ready;
  assign S_AXI_WREADY_O  = aw_ready;
  assign S_AXI_BVALID_O  = b_valid;
  assign S_AXI_BRESP_O   = b_resp;
  assign S_AXI_ARREADY_O = ar_ready;
  assign S_AXI_RVALID_O  = r_valid;
  assign S_AXI_RRESP_O   = r_resp;
  assign S_AXI_RDATA_O   = {24'h000000, r_data};
  assign PIN_O           = pin_o;
  assign PIN_OE_N_O      = pin_oe_n;
  assign SER_RXD_O       = rxd;
  assign SER_SCK_O       = sck_in;
  assign EXT_IRQ_N_O     = irq_n;

endmodule // fpp_port

/* tb/fpp_monitor.sv */
// assertions on the four-pin port's bus and pin outputs
module fpp_monitor (
  input wire logic        CORE_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  input wire logic        S_AXI_BVALID_O,
  input wire logic [17:0] S_AXI_ARADDR_I,
  input wire logic        S_AXI_ARVALID_I,
  input wire logic        S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic        S_AXI_RVALID_O,
  input wire logic [3:0]  PIN_I,
  input wire logic [2:0]  PIN_OE_N_O,
  input wire logic        SER_RXD_O,
  input wire logic        SER_SCK_O,
  input wire logic        EXT_IRQ_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  wire logic [15:0] rd_idx = S_AXI_ARADDR_I[17:2];
  sequence rd_take;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  endsequence
  sequence wr_take;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  endsequence
  a_rd_answer:
    assert property (rd_take |=> S_AXI_RVALID_O &&
      S_AXI_RDATA_O[31:8] == 24'h000000)
    else $error("read answer missing");
  a_dir_ones:
    assert property (rd_take ##0 rd_idx == fpp_pkg::IDX_DIR
      |=> S_AXI_RDATA_O[7:0] == 8'hff) else $error("direction read not ones");
  a_upper_ones:
    assert property (rd_take ##0 rd_idx == fpp_pkg::IDX_DATA
      |=> S_AXI_RDATA_O[7:4] == 4'hf) else $error("upper data bits not one");
  a_wr_answer:
    assert property (wr_take |=> S_AXI_BVALID_O) else $error("no write answer");
  a_irq_source:
    assert property (!EXT_IRQ_N_O |-> !$past(PIN_I[3]))
    else $error("interrupt line without pin low");
  a_rxd_source:
    assert property (!SER_RXD_O |-> !$past(PIN_I[1]))
    else $error("receive line without pin low");
  a_sck_source:
    assert property (!SER_SCK_O |-> !$past(PIN_I[0]))
    else $error("clock line without pin low");
  // reset checks must see the reset cycles themselves
  a_reset_float:
    assert property (disable iff (1'b0) !RSTN_I |=> PIN_OE_N_O == 3'b111)
    else $error("pins driven in reset");
  a_reset_idle:
    assert property (disable iff (1'b0) !RSTN_I |=> !S_AXI_BVALID_O &&
      !S_AXI_RVALID_O && EXT_IRQ_N_O && SER_RXD_O && SER_SCK_O)
    else $error("outputs not idle in reset");
endmodule // fpp_monitor

bind fpp_port fpp_monitor i_fpp_monitor (.CORE_CLK_I, .RSTN_I,
  .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_BVALID_O, .S_AXI_ARADDR_I,
  .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RVALID_O,
  .PIN_I, .PIN_OE_N_O, .SER_RXD_O, .SER_SCK_O, .EXT_IRQ_N_O);

/* tb/fpp_pins.sv */
// board-side model of the four port pins
module fpp_pins (
  input  wire logic [2:0] pin_o_i,
  input  wire logic [2:0] oe_n_i,
  input  wire logic [3:0] ext_i,
  output logic      [3:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pin shows the board's own level, never the last drive
  assign lvl_o = {ext_i[3], (~oe_n_i & pin_o_i) | (oe_n_i & ext_i[2:0])};
endmodule // fpp_pins

/* tb/testbench.sv */
// self-checking bench for the four-pin port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic txd = 1, sck = 1, awr, wrdy, bv, arr, rv, rxd, scko, irqn, c;
  logic [17:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, rdat;
  logic [1:0]  br, rr, rsp, wrsp;
  logic [3:0]  ext = 4'ha, lvl;
  logic [2:0]  po, oen, dir, dat;
  logic [7:0]  v;
  int fail_count = 0, num_checks = 0;
  fpp_port i_fpp_port (.S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(br),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry),
    .CORE_CLK_I(clk), .RSTN_I(rstn), .PIN_I(lvl), .PIN_O(po),
    .PIN_OE_N_O(oen), .SER_TXD_I(txd), .SER_SCK_I(sck),
    .SER_RXD_O(rxd), .SER_SCK_O(scko), .EXT_IRQ_N_O(irqn));
  fpp_pins i_fpp_pins (.pin_o_i(po), .oe_n_i(oen), .ext_i(ext), .lvl_o(lvl));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bus_wr(input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk);
    awa <= {idx, 2'b00};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    // each channel is let go at the edge its own ready is seen
    fork
      begin
        do @(posedge clk); while (awr !== 1'b1);
        awv <= 1'b0;
      end
      begin
        do @(posedge clk); while (wrdy !== 1'b1);
        wv <= 1'b0;
      end
    join
    do @(posedge clk); while (bv !== 1'b1);
    wrsp = br;
    bry <= 1'b0;
  endtask
  task automatic bus_rd(input logic [15:0] idx);
    @(posedge clk);
    ara <= {idx, 2'b00};
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rdat = rd;
    rsp = rr;
    rry <= 1'b0;
  endtask
  function automatic logic [31:0] exp_dat(input logic [2:0] dr, dt,
                                          input logic [3:0] p, input logic s);
    return {24'h0, 4'hf, s | p[3], (dr & dt) | (~dr & p[2:0])};
  endfunction
  // output pins only carry the latch where the direction bit is set
  task automatic pins_ok();
    repeat (3) @(posedge clk);
    chk({26'h0, oen, po & dir}, {26'h0, ~dir, dat & dir});
  endtask
  initial begin
    #50000;
    fail_count++;
    conclude();
  end
  initial begin
    void'($urandom(32'h5f9d7e90));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    chk({29'h0, oen}, 32'h7);
    bus_rd(fpp_pkg::IDX_DATA);
    chk(rdat, exp_dat(3'h0, 3'h0, ext, 1'b0));
    bus_rd(fpp_pkg::IDX_DIR);
    chk(rdat, 32'hff);
    bus_rd(16'h0100);
    chk({30'h0, rsp}, {30'h0, fpp_pkg::RESP_SLVERR});
    bus_wr(16'h0100, 8'h00);
    chk({30'h0, wrsp}, {30'h0, fpp_pkg::RESP_SLVERR});
    dir = 3'h7;
    dat = 3'h0;
    bus_wr(fpp_pkg::IDX_DIR, 8'h07);
    pins_ok();
    repeat (20) begin
      v = 8'($urandom);
      dir = v[2:0];
      dat = 3'($urandom);
      ext <= 4'($urandom);
      bus_wr(fpp_pkg::IDX_DIR, v);
      bus_wr(fpp_pkg::IDX_DATA, {~v[7:3], dat});
      pins_ok();
      bus_rd(fpp_pkg::IDX_DATA);
      chk(rdat, exp_dat(dir, dat, ext, 1'b0));
      chk({28'h0, wrsp, rsp}, {28'h0, fpp_pkg::RESP_OKAY,
          fpp_pkg::RESP_OKAY});
      bus_rd(fpp_pkg::IDX_DIR);
      chk(rdat, 32'hff);
    end
    bus_wr(fpp_pkg::IDX_SPIN, 8'h01);
    // serial use overrides whatever direction the last random pass left
    for (int k = 0; k < 3; k++) begin
      c = (k == 2);
      bus_wr(fpp_pkg::IDX_SCTL, c ? 8'h32 : {7'h18, k == 0});
      bus_wr(fpp_pkg::IDX_SMODE, {k != 0, 7'h0});
      txd <= 1'($urandom);
      sck <= 1'($urandom);
      ext <= 4'($urandom);
      repeat (3) @(posedge clk);
      chk({25'h0, oen, po[2], po[0] | c, rxd, scko}, {25'h0, 2'b01, c, txd,
          sck | c, ext[1], c ? ext[0] : 1'b1});
    end
    bus_wr(fpp_pkg::IDX_SCTL, 8'h00);
    // synchronous mode alone would still claim pin 0
    bus_wr(fpp_pkg::IDX_SMODE, 8'h00);
    pins_ok();
    bus_wr(fpp_pkg::IDX_IMODE, 8'h01);
    ext <= 4'h0;
    repeat (3) @(posedge clk);
    chk({31'h0, irqn}, 32'h0);
    bus_rd(fpp_pkg::IDX_DATA);
    chk(rdat, exp_dat(dir, dat, ext, 1'b1));
    bus_wr(fpp_pkg::IDX_DIR, 8'h07);
    bus_wr(fpp_pkg::IDX_DATA, 8'h07);
    bus_wr(fpp_pkg::IDX_PWR, 8'h02);
    bus_wr(fpp_pkg::IDX_DATA, 8'h00);
    repeat (3) @(posedge clk);
    chk({26'h0, oen, po}, 32'h07);
    bus_wr(fpp_pkg::IDX_PWR, 8'h03);
    repeat (3) @(posedge clk);
    chk({29'h0, oen}, 32'h7);
    bus_wr(fpp_pkg::IDX_PWR, 8'h01);
    repeat (3) @(posedge clk);
    chk({26'h0, oen, po}, 32'h00);
    conclude();
  end
endmodule // testbench
